// [logic/power_output_supervisor_pkg.sv]
// constants for the power output supervisor: register map, fields, timing
// assumes a 250 MHz system clock and an APB register port with byte addresses

package power_output_supervisor_pkg;

  // ----------------------------------------
  // register indexes, byte address is index * 4
  // ----------------------------------------
  localparam logic [5:0] IDX_SYSTEM_CONTROL = 6'h03;
  localparam logic [5:0] IDX_SYSTEM_STATUS = 6'h0c;
  localparam logic [5:0] IDX_WDT_CONTROL = 6'h10;
  localparam logic [5:0] IDX_INT_FLAG = 6'h11;
  localparam logic [5:0] IDX_POWER_OUTPUT = 6'h12;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_POWER_STAGE_ENABLE = 7;
  localparam int CTL_SLOPE_HIGH = 6;
  localparam int CTL_SLOPE_LOW = 5;
  localparam int CTL_ENTER_STOP = 0;
  localparam int STAT_SENSOR_OC = 7;
  localparam int STAT_LIN_LIMIT = 6;
  localparam int STAT_SUPPLY_OC = 5;
  localparam int STAT_LAMP_OC = 4;
  localparam int STAT_UNDERVOLTAGE = 3;
  localparam int STAT_OVERVOLTAGE = 2;
  localparam int STAT_BRIDGE_OC = 1;
  localparam int STAT_OVERTEMP = 0;
  localparam int WDT_RATE = 0;
  localparam int WDT_FLAG = 1;
  localparam int WDT_CYCLIC = 2;
  localparam int WDT_RESET_EN = 3;
  localparam int WDT_INT_EN = 4;
  localparam int WDT_RESTART = 5;
  localparam int PWR_LAMP_ON = 0;
  localparam int PWR_SUPPLY_ON = 1;
  localparam int PWR_OT_RESET_EN = 2;
  localparam int PWR_SENSOR_IRQ_EN = 3;
  localparam int PWR_SENSOR_SEL = 4;

  // ----------------------------------------
  // synchronised input positions
  // ----------------------------------------
  localparam int IN_UNDERVOLTAGE = 0;
  localparam int IN_OVERVOLTAGE = 1;
  localparam int IN_OT_WARNING = 2;
  localparam int IN_OT_LIMIT = 3;
  localparam int IN_LAMP_OC = 4;
  localparam int IN_SUPPLY_OC = 5;
  localparam int IN_BRIDGE_OC = 6;
  localparam int IN_SENSOR_OC = 7;
  localparam int IN_LIN_LIMIT = 8;
  localparam int IN_CHOP = 9;
  localparam int IN_SENSOR = 10;
  localparam int N_IN = 13;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int WDT_FAST_MS = 10;
  localparam int WDT_SLOW_MS = 20;
  localparam int WDT_FAST_CYCLES = WDT_FAST_MS * CLK_MHZ * 1000;
  localparam int WDT_SLOW_CYCLES = WDT_SLOW_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 23;
  localparam logic [2:0] SAMPLE_CYCLES = 3'h4;

  typedef enum logic [2:0] {
    ST_COUNT = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_WAKE = 3'b100
  } wdt_state_t;

endpackage

// [logic/power_output_supervisor.sv]
// power output supervisor: protection flags, control/status registers, watchdog
// assumes APB on sys_clk; fault inputs are asynchronous analog comparator levels
//
// Overview of operation
// - low or high voltage flag forces lamp off
// - write one clears voltage flag; persists re-sets
// - overtemp warning flag; limit resets, outputs off
// - lamp overcurrent switches lamp off, sets flag
// - chop input rising edge re-arms tripped lamp
// - lamp flag write one clears, zero ignored
// - supply on needs enable and own bit
// - supply overtemp cut only with reset enable
// - supply overcurrent trips output, status bit five
// - control bit seven gates all power stages
// - two slope bits select lin transmitter slope
// - stop bit cleared by reset or irq
// - sensor overcurrent sets bit seven, write clears
// - bit six shows lin current limitation
// - status bits mirror voltage, temperature flags
// - bridge overcurrent sets bit one, write clears
// - watchdog runs only with an enable set
// - reset watchdog run mode only, sticky enable
// - timeout with reset enable resets; stop pauses
// - stop mode interrupt enable gives periodic wake
// - cyclic check samples sensors, wakes on one
// - rate bit picks ten or twenty ms
// - timeout flag write one clears, restarts count
//
// Added by the designer: register access over APB.

`timescale 1ns/1ps

module power_output_supervisor #(
  parameter int FAST_CYCLES = power_output_supervisor_pkg::WDT_FAST_CYCLES,
  parameter int SLOW_CYCLES = power_output_supervisor_pkg::WDT_SLOW_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog fault and sense inputs
  input wire logic undervoltage_condition,
  input wire logic overvoltage_condition,
  input wire logic overtemp_warning,
  input wire logic overtemp_limit,
  input wire logic lamp_overcurrent,
  input wire logic supply_overcurrent,
  input wire logic bridge_overcurrent,
  input wire logic sensor_overcurrent,
  input wire logic lin_current_limit,
  input wire logic chopping_frequency_input,
  input wire logic [2:0] sensor_level,
  // microcontroller side
  input wire logic cpu_irq_request,
  // power stage controls
  output logic lamp_driver_output,
  output logic switched_supply_output,
  output logic bridge_enable,
  output logic lin_tx_enable,
  output logic sensor_source_enable,
  output logic [1:0] lin_slope,
  // system controls
  output logic stop_mode,
  output logic main_regulator_on,
  output logic sensor_power,
  output logic system_reset_request,
  output logic wake_irq_n
);

  typedef struct packed {
    logic [power_output_supervisor_pkg::N_IN-1:0] sync_a;
    logic [power_output_supervisor_pkg::N_IN-1:0] sync_b;
    logic chop_prev;
    logic power_stage_enable;
    logic [1:0] slope;
    logic stop;
    logic sensor_f;
    logic supply_f;
    logic lamp_f;
    logic uv_f;
    logic ov_f;
    logic bridge_f;
    logic ot_f;
    logic lamp_trip;
    logic rate;
    logic cyclic;
    logic reset_en;
    logic int_en;
    logic wdt_f;
    logic [power_output_supervisor_pkg::CNT_W-1:0] cnt;
    power_output_supervisor_pkg::wdt_state_t seq;
    logic [2:0] sample_cnt;
    logic lamp_on;
    logic supply_on;
    logic ot_reset_en;
    logic sensor_irq_en;
    logic [2:0] sensor_sel;
    logic lamp_out;
    logic supply_out;
    logic bridge_en;
    logic lin_en;
    logic src_en;
    logic sys_reset;
    logic regulator_on;
    logic irq_n;
    logic sensor_pwr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'b00};
  endfunction

  function automatic logic flag_next(input logic flag, input logic ev, input logic clr);
    return (flag & ~clr) | ev;
  endfunction

  logic [power_output_supervisor_pkg::N_IN-1:0] raw_in;
  assign raw_in = {sensor_level, chopping_frequency_input, lin_current_limit,
                   sensor_overcurrent, bridge_overcurrent, supply_overcurrent,
                   lamp_overcurrent, overtemp_limit, overtemp_warning,
                   overvoltage_condition, undervoltage_condition};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [power_output_supervisor_pkg::N_IN-1:0] in_s;
    logic wr;
    logic w_ctl;
    logic w_stat;
    logic w_wdt;
    logic w_int;
    logic w_pwr;
    logic ot_trip;
    logic wdt_end;
    logic cnt_en;
    logic restart;
    logic [power_output_supervisor_pkg::CNT_W-1:0] end_val;
    logic [7:0] rd;
    logic mapped;
    in_s = s.sync_b;
    next_s = s;
    next_s.sync_a = raw_in;
    next_s.sync_b = s.sync_a;
    next_s.chop_prev = in_s[power_output_supervisor_pkg::IN_CHOP];
    next_s.sys_reset = 1'b0;
    wr = psel & penable & pwrite & s.pready;
    w_ctl = wr & addr_hit(paddr, power_output_supervisor_pkg::IDX_SYSTEM_CONTROL);
    w_stat = wr & addr_hit(paddr, power_output_supervisor_pkg::IDX_SYSTEM_STATUS);
    w_wdt = wr & addr_hit(paddr, power_output_supervisor_pkg::IDX_WDT_CONTROL);
    w_int = wr & addr_hit(paddr, power_output_supervisor_pkg::IDX_INT_FLAG);
    w_pwr = wr & addr_hit(paddr, power_output_supervisor_pkg::IDX_POWER_OUTPUT);

    // control and output registers
    if (w_ctl) begin
      next_s.power_stage_enable = pwdata[power_output_supervisor_pkg::CTL_POWER_STAGE_ENABLE];
      next_s.slope = {pwdata[power_output_supervisor_pkg::CTL_SLOPE_HIGH],
                      pwdata[power_output_supervisor_pkg::CTL_SLOPE_LOW]};
      if (pwdata[power_output_supervisor_pkg::CTL_ENTER_STOP]) begin
        next_s.stop = 1'b1;
      end
    end
    if (cpu_irq_request) begin
      next_s.stop = 1'b0;
    end
    if (w_pwr) begin
      next_s.lamp_on = pwdata[power_output_supervisor_pkg::PWR_LAMP_ON];
      next_s.supply_on = pwdata[power_output_supervisor_pkg::PWR_SUPPLY_ON];
      next_s.ot_reset_en = pwdata[power_output_supervisor_pkg::PWR_OT_RESET_EN];
      next_s.sensor_irq_en = pwdata[power_output_supervisor_pkg::PWR_SENSOR_IRQ_EN];
      next_s.sensor_sel = pwdata[power_output_supervisor_pkg::PWR_SENSOR_SEL +: 3];
    end

    // sticky fault flags, set beats clear
    next_s.uv_f = flag_next(s.uv_f, in_s[power_output_supervisor_pkg::IN_UNDERVOLTAGE],
      w_int & pwdata[power_output_supervisor_pkg::STAT_UNDERVOLTAGE]);
    next_s.ov_f = flag_next(s.ov_f, in_s[power_output_supervisor_pkg::IN_OVERVOLTAGE],
      w_int & pwdata[power_output_supervisor_pkg::STAT_OVERVOLTAGE]);
    next_s.ot_f = flag_next(s.ot_f, in_s[power_output_supervisor_pkg::IN_OT_WARNING],
      w_int & pwdata[power_output_supervisor_pkg::STAT_OVERTEMP]);
    next_s.lamp_f = flag_next(s.lamp_f, in_s[power_output_supervisor_pkg::IN_LAMP_OC],
      w_stat & pwdata[power_output_supervisor_pkg::STAT_LAMP_OC]);
    next_s.supply_f = flag_next(s.supply_f, in_s[power_output_supervisor_pkg::IN_SUPPLY_OC],
      w_stat & pwdata[power_output_supervisor_pkg::STAT_SUPPLY_OC]);
    next_s.sensor_f = flag_next(s.sensor_f, in_s[power_output_supervisor_pkg::IN_SENSOR_OC],
      w_stat & pwdata[power_output_supervisor_pkg::STAT_SENSOR_OC]);
    next_s.bridge_f = flag_next(s.bridge_f, in_s[power_output_supervisor_pkg::IN_BRIDGE_OC],
      w_stat & pwdata[power_output_supervisor_pkg::STAT_BRIDGE_OC]);

    // lamp trip latch, re-armed by flag clear or chop edge
    next_s.lamp_trip = flag_next(s.lamp_trip, in_s[power_output_supervisor_pkg::IN_LAMP_OC],
      (w_stat & pwdata[power_output_supervisor_pkg::STAT_LAMP_OC]) |
      (in_s[power_output_supervisor_pkg::IN_CHOP] & ~s.chop_prev));

    // overtemperature shutdown
    ot_trip = s.ot_reset_en & in_s[power_output_supervisor_pkg::IN_OT_LIMIT];
    if (ot_trip) begin
      next_s.power_stage_enable = 1'b0;
      next_s.sys_reset = 1'b1;
    end

    // watchdog control register
    restart = w_wdt & (pwdata[power_output_supervisor_pkg::WDT_RESTART] |
                       pwdata[power_output_supervisor_pkg::WDT_FLAG]);
    if (w_wdt) begin
      next_s.rate = pwdata[power_output_supervisor_pkg::WDT_RATE];
      next_s.cyclic = pwdata[power_output_supervisor_pkg::WDT_CYCLIC];
      next_s.int_en = pwdata[power_output_supervisor_pkg::WDT_INT_EN];
      next_s.reset_en = s.reset_en | pwdata[power_output_supervisor_pkg::WDT_RESET_EN];
    end

    // watchdog counter
    end_val = s.rate ? power_output_supervisor_pkg::CNT_W'(FAST_CYCLES - 1)
                     : power_output_supervisor_pkg::CNT_W'(SLOW_CYCLES - 1);
    cnt_en = (s.seq == power_output_supervisor_pkg::ST_COUNT) &
             (s.stop ? (s.int_en | s.cyclic) : s.reset_en);
    wdt_end = cnt_en & (s.cnt >= end_val);
    next_s.wdt_f = flag_next(s.wdt_f, wdt_end,
      w_wdt & pwdata[power_output_supervisor_pkg::WDT_FLAG]);
    if (!(s.int_en | s.reset_en | s.cyclic) || restart || wdt_end) begin
      next_s.cnt = '0;
    end else if (cnt_en) begin
      next_s.cnt = s.cnt + 1'b1;
    end

    case (s.seq)
      power_output_supervisor_pkg::ST_COUNT: begin
        if (wdt_end && !s.stop) begin
          next_s.sys_reset = 1'b1;
        end else if (wdt_end && s.int_en) begin
          next_s.seq = power_output_supervisor_pkg::ST_WAKE;
        end else if (wdt_end && s.cyclic) begin
          next_s.seq = power_output_supervisor_pkg::ST_SAMPLE;
          next_s.sample_cnt = 3'h0;
        end
      end
      power_output_supervisor_pkg::ST_SAMPLE: begin
        next_s.sample_cnt = s.sample_cnt + 3'h1;
        if (s.sample_cnt == power_output_supervisor_pkg::SAMPLE_CYCLES - 3'h1) begin
          if (s.sensor_irq_en &&
              |(in_s[power_output_supervisor_pkg::IN_SENSOR +: 3] & s.sensor_sel)) begin
            next_s.seq = power_output_supervisor_pkg::ST_WAKE;
          end else begin
            next_s.seq = power_output_supervisor_pkg::ST_COUNT;
          end
        end
      end
      power_output_supervisor_pkg::ST_WAKE: begin
        if (!s.stop) begin
          next_s.seq = power_output_supervisor_pkg::ST_COUNT;
        end
      end
      default: begin
        next_s.seq = power_output_supervisor_pkg::ST_COUNT;
      end
    endcase
    if (!next_s.stop && next_s.seq == power_output_supervisor_pkg::ST_SAMPLE) begin
      next_s.seq = power_output_supervisor_pkg::ST_COUNT;
    end

    // power stage outputs
    next_s.lamp_out = s.power_stage_enable & s.lamp_on & ~s.uv_f & ~s.ov_f &
                      ~s.lamp_trip & ~ot_trip;
    next_s.supply_out = s.power_stage_enable & s.supply_on & ~s.supply_f &
                        ~ot_trip;
    next_s.bridge_en = s.power_stage_enable & ~s.bridge_f & ~s.uv_f & ~s.ov_f &
                       ~ot_trip;
    next_s.lin_en = s.power_stage_enable & ~ot_trip;
    next_s.src_en = s.power_stage_enable & ~s.sensor_f & ~ot_trip;
    next_s.sensor_pwr = (next_s.seq == power_output_supervisor_pkg::ST_SAMPLE);
    next_s.irq_n = ~(next_s.seq == power_output_supervisor_pkg::ST_WAKE);
    next_s.regulator_on = ~next_s.stop |
                          (next_s.seq == power_output_supervisor_pkg::ST_WAKE);

    // apb read data prepared in the setup cycle
    rd = power_output_supervisor_pkg::RESET_VALUE;
    mapped = 1'b1;
    if (addr_hit(paddr, power_output_supervisor_pkg::IDX_SYSTEM_CONTROL)) begin
      rd = {s.power_stage_enable, s.slope[1], s.slope[0], 5'h00};
    end else if (addr_hit(paddr, power_output_supervisor_pkg::IDX_SYSTEM_STATUS)) begin
      rd = {s.sensor_f, in_s[power_output_supervisor_pkg::IN_LIN_LIMIT], s.supply_f,
            s.lamp_f, s.uv_f, s.ov_f, s.bridge_f, s.ot_f};
    end else if (addr_hit(paddr, power_output_supervisor_pkg::IDX_WDT_CONTROL)) begin
      rd = {3'h0, s.int_en, s.reset_en, s.cyclic, s.wdt_f, s.rate};
    end else if (addr_hit(paddr, power_output_supervisor_pkg::IDX_INT_FLAG)) begin
      rd = {4'h0, s.uv_f, s.ov_f, 1'b0, s.ot_f};
    end else if (addr_hit(paddr, power_output_supervisor_pkg::IDX_POWER_OUTPUT)) begin
      rd = {1'b0, s.sensor_sel, s.sensor_irq_en, s.ot_reset_en, s.supply_on, s.lamp_on};
    end else begin
      mapped = 1'b0;
    end
    next_s.pready = psel & ~penable;
    next_s.prdata = (psel & ~penable) ? {24'h000000, rd} : 32'h00000000;
    next_s.pslverr = psel & ~penable & ~mapped;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.seq <= power_output_supervisor_pkg::ST_COUNT;
      s.irq_n <= 1'b1;
      s.regulator_on <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign lamp_driver_output = s.lamp_out;
  assign switched_supply_output = s.supply_out;
  assign bridge_enable = s.bridge_en;
  assign lin_tx_enable = s.lin_en;
  assign sensor_source_enable = s.src_en;
  assign lin_slope = s.slope;
  assign stop_mode = s.stop;
  assign main_regulator_on = s.regulator_on;
  assign sensor_power = s.sensor_pwr;
  assign system_reset_request = s.sys_reset;
  assign wake_irq_n = s.irq_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_lamp_volt_off: assert property ((s.uv_f | s.ov_f) |=> !lamp_driver_output)
    else $error("lamp on during voltage fault");
  a_volt_set_wins: assert property (s.sync_b[power_output_supervisor_pkg::IN_UNDERVOLTAGE]
    |=> s.uv_f)
    else $error("undervoltage flag lost");
  a_ot_shutdown: assert property ((s.ot_reset_en &
    s.sync_b[power_output_supervisor_pkg::IN_OT_LIMIT]) |=> system_reset_request &&
    !switched_supply_output && !lamp_driver_output && !s.power_stage_enable)
    else $error("overtemperature did not shut down");
  a_lamp_oc_trip: assert property (s.sync_b[power_output_supervisor_pkg::IN_LAMP_OC]
    |=> s.lamp_f && s.lamp_trip ##1 !lamp_driver_output)
    else $error("lamp overcurrent not tripped");
  a_chop_rearm: assert property ((s.lamp_trip &&
    !s.sync_b[power_output_supervisor_pkg::IN_LAMP_OC] &&
    s.sync_b[power_output_supervisor_pkg::IN_CHOP] && !s.chop_prev) |=> !s.lamp_trip)
    else $error("chop edge did not re-arm lamp");
  a_supply_gate: assert property (switched_supply_output |->
    $past(s.power_stage_enable) && $past(s.supply_on) && !$past(s.supply_f))
    else $error("supply on without enables");
  a_stop_clear: assert property (cpu_irq_request |=> !stop_mode)
    else $error("stop bit not cleared by interrupt");
  a_wdt_sticky: assert property (s.reset_en |=> s.reset_en)
    else $error("watchdog reset enable dropped");
  a_wdt_off: assert property (!(s.int_en | s.reset_en | s.cyclic) |=> s.cnt == '0)
    else $error("watchdog counting while off");
  a_wdt_pause: assert property ((s.stop && !s.int_en && !s.cyclic) |=>
    $stable(s.cnt) || s.cnt == '0)
    else $error("watchdog counted in stop mode");
  a_wake_stop: assert property ($fell(wake_irq_n) |-> stop_mode && main_regulator_on)
    else $error("wake outside stop mode");

  c_lamp_rearm: cover property (s.lamp_trip ##1 !s.lamp_trip ##[1:20] lamp_driver_output);
  c_wdt_reset: cover property (!stop_mode && s.reset_en ##[1:200] system_reset_request);
  c_cyclic_wake: cover property (sensor_power ##[1:8] !wake_irq_n);

endmodule

// [verif/cpu_master.sv]
// cpu side model: apb master issuing register reads and writes
// assumes the supervisor answers on the same sys_clk

`timescale 1ns/1ps

module cpu_master (
  // clock
  input wire logic sys_clk,
  // apb request
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic timed_out = 1'b0;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ----------------------------------------
  // one transfer: setup, access, wait for pready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    q = prdata[7:0];
    e = pslverr;
    timed_out = (n >= 50);
    // released lines stop showing the old request
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
endmodule

// [verif/power_output_supervisor_bench.sv]
// self-checking bench for the power output supervisor
// assumes cpu_master drives the apb port; sys_clk at 250 MHz

`timescale 1ns/1ps

module power_output_supervisor_bench;
  localparam logic [7:0] adr_ctl = {power_output_supervisor_pkg::IDX_SYSTEM_CONTROL, 2'b00};
  localparam logic [7:0] adr_stat = {power_output_supervisor_pkg::IDX_SYSTEM_STATUS, 2'b00};
  localparam logic [7:0] adr_wdt = {power_output_supervisor_pkg::IDX_WDT_CONTROL, 2'b00};
  localparam logic [7:0] adr_ifr = {power_output_supervisor_pkg::IDX_INT_FLAG, 2'b00};
  localparam logic [7:0] adr_pwr = {power_output_supervisor_pkg::IDX_POWER_OUTPUT, 2'b00};
  localparam logic [31:0] ocm = 32'h80200210;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] vv = 2'h0;
  logic [3:0] ocv = 4'h0;
  logic otw = 1'b0;
  logic otl = 1'b0;
  logic lcl = 1'b0;
  logic chop = 1'b0;
  logic irq = 1'b0;
  logic [2:0] sens = 3'h0;
  wire logic [7:0] paddr;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [31:0] pwdata, prdata;
  wire logic lamp, sup, bre, lte, sse, stp, mreg, srr, wirq_n, spw;
  int spw_n = 0;
  wire logic [1:0] slope;
  wire logic [2:0] outs = {sup, bre, lamp};
  int err_total = 0;
  int total_checks = 0;
  int n, n0;
  int rst_seen = 0;
  logic [7:0] q, m;
  logic e;
  logic [31:0] r;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (srr === 1'b1) rst_seen++;
  always @(posedge sys_clk) if (spw === 1'b1) spw_n++;

  cpu_master cpu_u (.sys_clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  power_output_supervisor #(.FAST_CYCLES(40), .SLOW_CYCLES(80)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .undervoltage_condition(vv[0]), .overvoltage_condition(vv[1]), .overtemp_warning(otw),
    .overtemp_limit(otl), .lamp_overcurrent(ocv[0]), .supply_overcurrent(ocv[2]),
    .bridge_overcurrent(ocv[1]), .sensor_overcurrent(ocv[3]), .lin_current_limit(lcl),
    .chopping_frequency_input(chop), .sensor_level(sens), .cpu_irq_request(irq),
    .lamp_driver_output(lamp), .switched_supply_output(sup), .bridge_enable(bre),
    .lin_tx_enable(lte), .sensor_source_enable(sse), .lin_slope(slope), .stop_mode(stp),
    .main_regulator_on(mreg), .sensor_power(spw), .system_reset_request(srr),
    .wake_irq_n(wirq_n));

  // ----------------------------------------
  // checks, bus access, waits
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cpu_u.xfer(w, a, d, q, e);
    if (cpu_u.timed_out) begin
      err_total++;
      $display("BAD %0t bus hang", $time);
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k = 8'hff);
    bus(1'b0, a, 8'h00);
    chk_reg(q & k, x & k);
  endtask
  task automatic wait_sig(input int which, input int lim);
    n = 0;
    while (((which == 0) ? srr : ~wirq_n) !== 1'b1) begin
      n++;
      if (n > lim) begin
        err_total++;
        $display("BAD %0t wait ran out", $time);
        print_verdict();
      end
      @(posedge sys_clk);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hed3ed463));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(1);
    chk_bit(wirq_n, 1'b1);
    rd(adr_ctl, 8'h00);
    rd(adr_stat, 8'h00);
    bus(1'b0, 8'hfc, 8'h00);
    chk_bit(e, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      m = {r[7], 2'(i), 5'h00};
      bus(1'b1, adr_ctl, m | 8'h1e);
      rd(adr_ctl, m);
      chk_reg({6'h0, slope}, 8'(i));
      chk_bit(lte, r[7]);
      chk_bit(sse, r[7]);
    end
    bus(1'b1, adr_ctl, 8'h80);
    bus(1'b1, adr_pwr, 8'h03);
    rd(adr_pwr, 8'h03, 8'h03);
    chk_bit(sup, 1'b1);
    for (int k = 0; k < 4; k++) begin
      m = ocm[8*k +: 8];
      ocv <= 4'h1 << k;
      cyc(6);
      rd(adr_stat, m);
      if (k < 3) chk_bit(outs[k], 1'b0);
      bus(1'b1, adr_stat, m);
      rd(adr_stat, m);
      ocv <= 4'h0;
      r = $urandom;
      bus(1'b1, adr_stat, r[7:0] & ~m & 8'h4d);
      rd(adr_stat, m);
      if (k == 0) begin
        chop <= 1'b1;
        cyc(6);
        chk_bit(lamp, 1'b1);
        chop <= 1'b0;
      end
      bus(1'b1, adr_stat, m);
      rd(adr_stat, 8'h00);
      if (k < 3) chk_bit(outs[k], 1'b1);
    end
    for (int j = 0; j < 2; j++) begin
      m = 8'h08 >> j;
      vv <= 2'h1 << j;
      cyc(6);
      chk_bit(lamp, 1'b0);
      chk_bit(sup, 1'b1);
      rd(adr_stat, m);
      bus(1'b1, adr_ifr, m);
      rd(adr_ifr, m);
      vv <= 2'h0;
      cyc(6);
      bus(1'b1, adr_ifr, m);
      rd(adr_stat, 8'h00);
      chk_bit(lamp, 1'b1);
    end
    lcl <= 1'b1;
    cyc(6);
    bus(1'b1, adr_stat, 8'h40);
    rd(adr_stat, 8'h40);
    lcl <= 1'b0;
    cyc(6);
    rd(adr_stat, 8'h00);
    otw <= 1'b1;
    cyc(6);
    rd(adr_stat, 8'h01);
    otw <= 1'b0;
    cyc(6);
    bus(1'b1, adr_ifr, 8'h01);
    bus(1'b1, adr_pwr, 8'h07);
    otl <= 1'b1;
    wait_sig(0, 20);
    otl <= 1'b0;
    cyc(4);
    chk_bit(lamp, 1'b0);
    chk_bit(sup, 1'b0);
    rd(adr_ctl, 8'h00, 8'h80);
    bus(1'b1, adr_wdt, 8'h11);
    bus(1'b1, adr_ctl, 8'h01);
    cyc(2);
    chk_bit(stp, 1'b1);
    chk_bit(mreg, 1'b0);
    wait_sig(1, 200);
    cyc(1);
    chk_bit(mreg, 1'b1);
    irq <= 1'b1;
    cyc(1);
    irq <= 1'b0;
    cyc(3);
    chk_bit(stp, 1'b0);
    chk_bit(wirq_n, 1'b1);
    cyc(150);
    chk_bit(wirq_n, 1'b1);
    bus(1'b1, adr_wdt, 8'h2a);
    bus(1'b1, adr_wdt, 8'h28);
    n0 = rst_seen;
    for (int i = 0; i < 4; i++) begin
      cyc(50);
      bus(1'b1, adr_wdt, 8'h28);
    end
    chk_bit(rst_seen == n0, 1'b1);
    wait_sig(0, 200);
    chk_bit(n > 60 && n <= 85, 1'b1);
    rd(adr_wdt, 8'h0a, 8'h0a);
    bus(1'b1, adr_wdt, 8'h02);
    rd(adr_wdt, 8'h08, 8'h0a);
    bus(1'b1, adr_wdt, 8'h29);
    wait_sig(0, 200);
    chk_bit(n > 30 && n <= 45, 1'b1);
    sens <= 3'h1;
    bus(1'b1, adr_pwr, 8'h18);
    bus(1'b1, adr_wdt, 8'h0d);
    bus(1'b1, adr_ctl, 8'h01);
    wait_sig(1, 200);
    cyc(1);
    chk_bit(spw_n == 4, 1'b1);
    chk_bit(mreg, 1'b1);
    irq <= 1'b1;
    cyc(1);
    irq <= 1'b0;
    cyc(3);
    chk_bit(stp, 1'b0);
    print_verdict();
  end
endmodule
